// [logic/ocl_pkg.sv]
// constants for the overcurrent low limit and aux converter config bank
// assumes a 32-bit classic wishbone register bus, one word per register
package ocl_pkg;
  // ==================================================================
  // register indices (byte address is index times four)
  localparam logic [7:0] OCL_IDX_LOW_LIMIT = 8'h89;
  localparam logic [7:0] OCL_IDX_SCRATCH = 8'h8a;
  localparam logic [7:0] OCL_IDX_AUX_CFG1 = 8'h8b;
  localparam logic [7:0] OCL_IDX_STATUS = 8'hc0;
  localparam logic [7:0] OCL_IDX_MASK = 8'hc1;
  localparam logic [7:0] OCL_IDX_CTRL = 8'hc2;
  localparam logic [7:0] OCL_IDX_CRC = 8'hc3;
  // ==================================================================
  // reset values, disable code, write mask and crc constants
  localparam logic [15:0] OCL_RST_LOW_LIMIT = 16'h8000;
  localparam logic [15:0] OCL_LOW_DISABLE = 16'h8000;
  localparam logic [15:0] OCL_RST_SCRATCH = 16'h5555;
  localparam logic [15:0] OCL_RST_AUX_CFG1 = 16'h8010;
  localparam logic [15:0] OCL_AUX_CFG1_WMASK = 16'h87ff;
  localparam logic [15:0] OCL_CRC_SEED = 16'hffff;
  localparam logic [15:0] OCL_CRC_POLY = 16'h1021;
  // ==================================================================
  // field positions in aux config one
  localparam int OCL_F_ENABLE = 15;
  localparam int OCL_F_CM_BUF = 10;
  localparam int OCL_F_SRC_SEL = 7;
  localparam int OCL_F_SNK_SEL = 4;
  localparam int OCL_F_SRC_LVL = 2;
  localparam int OCL_F_SNK_LVL = 0;
  // status bits
  localparam int OCL_S_LOW = 0;
  localparam int OCL_S_HIGH = 1;
  localparam int OCL_S_FAULT = 2;
  // ctrl bits
  localparam int OCL_C_STANDBY = 0;
  localparam int OCL_C_PWRDN = 1;
  // ==================================================================
  // crc walk states
  typedef enum logic [1:0] {
    OCL_CRC_IDLE = 2'b01,
    OCL_CRC_RUN = 2'b10
  } ocl_crc_state_t;
endpackage : ocl_pkg

// [logic/ocl_bank.sv]
// register bank: overcurrent low limit, crc scratch, aux converter config one
// assumes classic wishbone master on clk_i; fast-filter results arrive as
// same-clock strobed samples; high-side comparator runs outside this bank
//
// Summary of operation
// - low limit is a signed 16-bit value scaled by reference over gain
// - low event flag rises when fast result is below the low limit
// - most negative limit turns low detection off; this is the reset value
// - scratch register is 16-bit read/write, resets to 5555h, no effect
// - scratch contents are folded into the section three register crc
// - aux enable clear zeroes aux result and two-bit sequence counter
// - standby or power-down also zeroes aux result and sequence counter
// - bit 10 drives the common-mode buffer enable on aux input seven
// - three-bit code routes open-wire source to aux input 0 to 7
// - separate three-bit code at bits 6:4 routes open-wire sink, resetting to input 1
// - two-bit source level code: off, 4, 40, 240 microamps
// - two-bit sink level code with the same encoding, off by default
// - fault output is active while any high or low event flag is active
// - consecutive out-of-limit conversions counted, restart when back inside
`timescale 1ns/100ps
module ocl_bank
  import ocl_pkg::*;
#(
  parameter int DEGLITCH_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [15:0] fast_result_i,
  input wire logic fast_valid_i,
  input wire logic [DEGLITCH_W-1:0] deglitch_count_i,
  input wire logic overcurrent_high_event_flag_i,
  output logic overcurrent_low_event_flag_o,
  output logic overcurrent_fault_output_o,
  output logic irq_o,
  output logic aux_converter_enable_o,
  output logic aux_clear_o,
  output logic common_mode_buffer_enable_o,
  output logic [2:0] open_wire_source_select_o,
  output logic [2:0] open_wire_sink_select_o,
  output logic [1:0] open_wire_source_level_o,
  output logic [1:0] open_wire_sink_level_o
);
  // ==================================================================
  // registers
  logic [15:0] low_limit_r;
  logic [15:0] scratch_r;
  logic [15:0] aux_cfg_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [1:0] ctrl_r;
  logic [15:0] crc_r;
  logic [15:0] crc_acc_r;
  logic [1:0] crc_step_r;
  ocl_crc_state_t crc_state_r;
  logic [DEGLITCH_W-1:0] beyond_cnt_r;
  logic low_flag_r;
  logic high_q_r;
  logic fault_q_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // ==================================================================
  // bus decode
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic addr_ok;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0];
  assign addr_ok = (wb_adr_i[31:10] == 22'h0) && (wb_adr_i[1:0] == 2'h0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // unmapped addresses read zero, writes ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 32'h0;
    else if (req && !wb_we_i)
    begin
      rdata_r <= 32'h0;
      if (addr_ok)
      begin
        case (idx)
          OCL_IDX_LOW_LIMIT: rdata_r[15:0] <= low_limit_r;
          OCL_IDX_SCRATCH: rdata_r[15:0] <= scratch_r;
          OCL_IDX_AUX_CFG1: rdata_r[15:0] <= aux_cfg_r;
          OCL_IDX_STATUS: rdata_r[2:0] <= status_r;
          OCL_IDX_MASK: rdata_r[2:0] <= mask_r;
          OCL_IDX_CTRL: rdata_r[1:0] <= ctrl_r;
          OCL_IDX_CRC: rdata_r[15:0] <= crc_r;
          default: rdata_r <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ==================================================================
  // register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      low_limit_r <= OCL_RST_LOW_LIMIT;
    else if (wr && addr_ok && idx == OCL_IDX_LOW_LIMIT)
      low_limit_r <= (low_limit_r & ~wmask) | (wdata & wmask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      scratch_r <= OCL_RST_SCRATCH;
    else if (wr && addr_ok && idx == OCL_IDX_SCRATCH)
      scratch_r <= (scratch_r & ~wmask) | (wdata & wmask);
  end

  // reserved bits 14:11 stay zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      aux_cfg_r <= OCL_RST_AUX_CFG1;
    else if (wr && addr_ok && idx == OCL_IDX_AUX_CFG1)
      aux_cfg_r <= (aux_cfg_r & ~(wmask & OCL_AUX_CFG1_WMASK)) | (wdata & wmask & OCL_AUX_CFG1_WMASK);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_r <= 3'h0;
    else if (wr && addr_ok && idx == OCL_IDX_MASK && wb_sel_i[0])
      mask_r <= wdata[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= 2'h0;
    else if (wr && addr_ok && idx == OCL_IDX_CTRL && wb_sel_i[0])
      ctrl_r <= wdata[1:0];
  end

  // ==================================================================
  // aux converter config outputs
  assign aux_converter_enable_o = aux_cfg_r[OCL_F_ENABLE];
  // result and sequence counter held cleared outside this bank
  assign aux_clear_o = !aux_cfg_r[OCL_F_ENABLE]
    || ctrl_r[OCL_C_STANDBY] || ctrl_r[OCL_C_PWRDN];
  assign common_mode_buffer_enable_o = aux_cfg_r[OCL_F_CM_BUF];
  assign open_wire_source_select_o = aux_cfg_r[OCL_F_SRC_SEL +: 3];
  assign open_wire_sink_select_o = aux_cfg_r[OCL_F_SNK_SEL +: 3];
  assign open_wire_source_level_o = aux_cfg_r[OCL_F_SRC_LVL +: 2];
  assign open_wire_sink_level_o = aux_cfg_r[OCL_F_SNK_LVL +: 2];

  // ==================================================================
  // low-threshold comparator with deglitch count
  logic below;
  assign below = ($signed(fast_result_i) < $signed(low_limit_r))
    && (low_limit_r != OCL_LOW_DISABLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      beyond_cnt_r <= '0;
      low_flag_r <= 1'b0;
    end
    else if (fast_valid_i)
    begin
      if (!below)
      begin
        beyond_cnt_r <= '0;
        low_flag_r <= 1'b0;
      end
      else
      begin
        if (beyond_cnt_r != {DEGLITCH_W{1'b1}})
          beyond_cnt_r <= beyond_cnt_r + 1'b1;
        if (beyond_cnt_r >= deglitch_count_i)
          low_flag_r <= 1'b1;
      end
    end
  end

  assign overcurrent_low_event_flag_o = low_flag_r;
  assign overcurrent_fault_output_o = low_flag_r || overcurrent_high_event_flag_i;

  // ==================================================================
  // sticky status, write one to clear, set wins
  logic [2:0] ev;
  // low bit re-sets while the flag stands; a clear sticks once it drops
  // (level event, so the set always wins over a clear in the same cycle)
  assign ev[OCL_S_LOW] = low_flag_r;
  assign ev[OCL_S_HIGH] = overcurrent_high_event_flag_i && !high_q_r;
  assign ev[OCL_S_FAULT] = overcurrent_fault_output_o && !fault_q_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      high_q_r <= 1'b0;
      fault_q_r <= 1'b0;
    end
    else
    begin
      high_q_r <= overcurrent_high_event_flag_i;
      fault_q_r <= overcurrent_fault_output_o;
    end
  end

  logic [2:0] w1c;
  assign w1c = (wr && addr_ok && idx == OCL_IDX_STATUS && wb_sel_i[0]) ? wdata[2:0] : 3'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_r <= 3'h0;
    else
      status_r <= (status_r & ~w1c) | ev;
  end

  assign irq_o = |(status_r & mask_r);

  // ==================================================================
  // section crc over the three bank registers, rerun continuously
  logic [15:0] crc_word;
  logic [15:0] crc_next;
  always_comb
  begin
    case (crc_step_r)
      2'd0: crc_word = low_limit_r;
      2'd1: crc_word = scratch_r;
      default: crc_word = aux_cfg_r;
    endcase
    crc_next = crc_acc_r;
    for (int b = 15; b >= 0; b--)
    begin
      if (crc_next[15] ^ crc_word[b])
        crc_next = (crc_next << 1) ^ OCL_CRC_POLY;
      else
        crc_next = crc_next << 1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crc_state_r <= OCL_CRC_IDLE;
      crc_acc_r <= OCL_CRC_SEED;
      crc_step_r <= 2'd0;
      crc_r <= 16'h0;
    end
    else
    begin
      case (crc_state_r)
        OCL_CRC_IDLE:
        begin
          crc_acc_r <= OCL_CRC_SEED;
          crc_step_r <= 2'd0;
          crc_state_r <= OCL_CRC_RUN;
        end
        OCL_CRC_RUN:
        begin
          crc_acc_r <= crc_next;
          if (crc_step_r == 2'd2)
          begin
            crc_r <= crc_next;
            crc_state_r <= OCL_CRC_IDLE;
          end
          else
            crc_step_r <= crc_step_r + 2'd1;
        end
        default: crc_state_r <= OCL_CRC_IDLE;
      endcase
    end
  end
endmodule : ocl_bank

// [verif/ocl_bank_props.sv]
// port checker for the ocl_bank register bank
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/100ps
module ocl_bank_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic fast_valid_i,
  input wire logic overcurrent_high_event_flag_i,
  input wire logic overcurrent_low_event_flag_o,
  input wire logic overcurrent_fault_output_o,
  input wire logic aux_converter_enable_o,
  input wire logic aux_clear_o,
  input wire logic common_mode_buffer_enable_o,
  input wire logic [2:0] open_wire_source_select_o,
  input wire logic [2:0] open_wire_sink_select_o,
  input wire logic [1:0] open_wire_source_level_o,
  input wire logic [1:0] open_wire_sink_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [11:0] cfg_w;
  assign cfg_w = {aux_converter_enable_o, common_mode_buffer_enable_o, open_wire_source_select_o,
    open_wire_sink_select_o, open_wire_source_level_o, open_wire_sink_level_o};
  // ==========
  // assertions
  ack_one_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_time_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  fault_or_a:
    assert property (overcurrent_fault_output_o == (overcurrent_low_event_flag_o || overcurrent_high_event_flag_i))
    else $error("fault not or of flags");
  clear_off_a:
    assert property (!aux_converter_enable_o |-> aux_clear_o) else $error("no clear while disabled");
  flag_hold_a:
    assert property (!fast_valid_i |=> $stable(overcurrent_low_event_flag_o)) else $error("flag moved");
  flag_cause_a:
    assert property ($rose(overcurrent_low_event_flag_o) |-> $past(fast_valid_i)) else $error("flag rose alone");
  sink_reset_a:
    assert property ($fell(rst_i) |-> open_wire_sink_select_o == 3'h1) else $error("sink reset wrong");
  cfg_write_a:
    assert property ($changed(cfg_w) |-> wb_ack_o && wb_we_i) else $error("config moved alone");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(overcurrent_low_event_flag_o));
  cover property ($rose(aux_clear_o));
endmodule : ocl_bank_props
bind ocl_bank ocl_bank_props u_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o),
  .fast_valid_i(fast_valid_i),
  .overcurrent_high_event_flag_i(overcurrent_high_event_flag_i),
  .overcurrent_low_event_flag_o(overcurrent_low_event_flag_o),
  .overcurrent_fault_output_o(overcurrent_fault_output_o),
  .aux_converter_enable_o(aux_converter_enable_o),
  .aux_clear_o(aux_clear_o),
  .common_mode_buffer_enable_o(common_mode_buffer_enable_o),
  .open_wire_source_select_o(open_wire_source_select_o),
  .open_wire_sink_select_o(open_wire_sink_select_o),
  .open_wire_source_level_o(open_wire_source_level_o),
  .open_wire_sink_level_o(open_wire_sink_level_o)
);

// [verif/testbench.sv]
// self-checking bench for ocl_bank
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module testbench;
  import ocl_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic fast_valid_i = 0, overcurrent_high_event_flag_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 0;
  logic [15:0] fast_result_i = 0, d, c;
  logic [7:0] deglitch_count_i = 0;
  logic wb_ack_o, overcurrent_low_event_flag_o, overcurrent_fault_output_o, irq_o;
  logic aux_converter_enable_o, aux_clear_o, common_mode_buffer_enable_o;
  logic [2:0] open_wire_source_select_o, open_wire_sink_select_o, k;
  logic [1:0] open_wire_source_level_o, open_wire_sink_level_o;
  int fail_count = 0, comparisons = 0;
  ocl_bank dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .fast_result_i(fast_result_i),
    .fast_valid_i(fast_valid_i),
    .deglitch_count_i(deglitch_count_i),
    .overcurrent_high_event_flag_i(overcurrent_high_event_flag_i),
    .overcurrent_low_event_flag_o(overcurrent_low_event_flag_o),
    .overcurrent_fault_output_o(overcurrent_fault_output_o),
    .irq_o(irq_o),
    .aux_converter_enable_o(aux_converter_enable_o),
    .aux_clear_o(aux_clear_o),
    .common_mode_buffer_enable_o(common_mode_buffer_enable_o),
    .open_wire_source_select_o(open_wire_source_select_o),
    .open_wire_sink_select_o(open_wire_sink_select_o),
    .open_wire_source_level_o(open_wire_source_level_o),
    .open_wire_sink_level_o(open_wire_sink_level_o)
  );
  always #20 clk_i = ~clk_i;
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= {22'h0, a, 2'h0};
    wb_dat_i <= {16'h0, v};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0, 4'h3);
    chk(nm, e, q);
  endtask : rd
  task automatic conv(input logic [15:0] r, input logic e);
    @(posedge clk_i);
    fast_valid_i <= 1'b1;
    fast_result_i <= r;
    @(posedge clk_i);
    fast_valid_i <= 1'b0;
    @(posedge clk_i);
    chk("low flag", {31'h0, e}, {31'h0, overcurrent_low_event_flag_o});
  endtask : conv
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // ==========
  // tests
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test;
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("limit", 8'h89, 32'h8000);
    rd("scratch", 8'h8a, 32'h5555);
    rd("aux cfg", 8'h8b, 32'h8010);
    $display("reset test done");
    bus(1'b0, 8'hc3, 16'h0, 4'h3);
    c = q[15:0];
    bus(1'b1, 8'h8a, 16'h1234, 4'h1);
    rd("scratch", 8'h8a, 32'h5534);
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'hc3, 16'h0, 4'h3);
    chk("crc moved", 32'h1, {31'h0, q[15:0] !== c});
    bus(1'b1, 8'h8a, 16'h5555, 4'h3);
    repeat (8) @(posedge clk_i);
    rd("crc back", 8'hc3, {16'h0, c});
    bus(1'b1, 8'h50, 16'hffff, 4'h3);
    rd("unmapped", 8'h50, 32'h0);
    $display("scratch test done");
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      d = {5'h0, k[0], k, k, k[1:0], k[1:0]};
      bus(1'b1, 8'h8b, d, 4'h3);
      chk("aux fields", {19'h0, 2'b01, d[10:0]}, {19'h0, aux_converter_enable_o, aux_clear_o,
        common_mode_buffer_enable_o, open_wire_source_select_o, open_wire_sink_select_o,
        open_wire_source_level_o, open_wire_sink_level_o});
      rd("aux cfg", 8'h8b, {16'h0, d});
    end
    bus(1'b1, 8'h8b, 16'hffff, 4'h3);
    rd("aux cfg", 8'h8b, 32'h87ff);
    chk("clear", 32'h0, {31'h0, aux_clear_o});
    chk("enable", 32'h1, {31'h0, aux_converter_enable_o});
    for (int j = 1; j < 3; j++)
    begin
      bus(1'b1, 8'hc2, j[15:0], 4'h3);
      chk("mode clear", 32'h1, {31'h0, aux_clear_o});
    end
    bus(1'b1, 8'hc2, 16'h0, 4'h3);
    $display("aux test done");
    conv(16'h8000, 1'b0);
    bus(1'b1, 8'h89, 16'hfff0, 4'h3);
    bus(1'b1, 8'hc1, 16'h0007, 4'h3);
    conv(16'hfff0, 1'b0);
    conv(16'h7fff, 1'b0);
    conv(16'hffef, 1'b1);
    chk("fault", 32'h1, {31'h0, overcurrent_fault_output_o});
    @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    conv(16'h0010, 1'b0);
    rd("status", 8'hc0, 32'h5);
    bus(1'b1, 8'hc0, 16'h0007, 4'h3);
    rd("status", 8'hc0, 32'h0);
    deglitch_count_i <= 8'h1;
    conv(16'hffef, 1'b0);
    conv(16'h0000, 1'b0);
    conv(16'hffef, 1'b0);
    conv(16'hffef, 1'b1);
    bus(1'b1, 8'hc1, 16'h0, 4'h3);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b1, 8'hc1, 16'h0001, 4'h3);
    chk("irq open", 32'h1, {31'h0, irq_o});
    rd("mask", 8'hc1, 32'h1);
    conv(16'h0000, 1'b0);
    bus(1'b1, 8'hc0, 16'h0007, 4'h3);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    $display("comparator test done");
    overcurrent_high_event_flag_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    chk("fault high", 32'h1, {31'h0, overcurrent_fault_output_o});
    rd("status", 8'hc0, 32'h6);
    $display("high test done");
    stop_test;
  end
endmodule : testbench
